// ### rtl/twu_defs.svh
`ifndef TWU_DEFS_SVH
`define TWU_DEFS_SVH

// Register byte offsets on the APB.
`define TWU_OFS_CTRL     8'h00
`define TWU_OFS_STATUS   8'h20
`define TWU_OFS_IRQ_EN   8'h24
`define TWU_OFS_IRQ_DIS  8'h28
`define TWU_OFS_IRQ_MASK 8'h2C
`define TWU_OFS_RX_HOLD  8'h30
`define TWU_OFS_TX_HOLD  8'h34

// Status, enable, disable and mask bit positions.
`define TWU_B_TCOMP     0
`define TWU_B_RX_FULL   1
`define TWU_B_TX_EMPTY  2
`define TWU_B_RD_DIR    3
`define TWU_B_ADDRESSED 4
`define TWU_B_GEN_CALL  5
`define TWU_B_OVERRUN   6
`define TWU_B_NOT_ACK_FLAG      8
`define TWU_B_ARB       9
`define TWU_B_STRETCH   10
`define TWU_B_ACC_END   11

// Master enable command bit in the control register.
`define TWU_B_MASTER_EN 2

// Bits that hold interrupt sources (bit 3 and bit 7 are unused).
`define TWU_IRQ_BITS 12'hF77

// Constant upper status bits and reset values.
`define TWU_SR_HIGH  32'h0000_F000
`define TWU_ZERO32   32'h0000_0000
`define TWU_ZERO12   12'h000
`define TWU_ZERO8    8'h00

`endif

// ### rtl/twu_pkg.sv
package twu_pkg;

	// Operating mode of the serial engine, one-hot.
	typedef enum logic [2:0]
	{
		TWU_IDLE   = 3'b001,
		TWU_MASTER = 3'b010,
		TWU_SLAVE  = 3'b100
	} twu_mode_e;

	// One bit per status position 11..0.
	typedef logic [11:0] twu_flags_t;

	// One received or transmitted byte.
	typedef logic [7:0] twu_byte_t;

endpackage

// ### rtl/twu_status_irq.sv
// Overview of operation
// [RQ1] Master: THR write clears transmit-empty flag.
// [RQ2] Master: shifter load or NOT_ACK_FLAG sets it.
// [RQ3] Master enable command sets transmit-empty.
// [RQ4] Slave: empty flag low until byte acknowledged.
// [RQ5] Slave: stop sending when empty and NOT_ACK_FLAG.
// [RQ6] Software never writes THR while NOT_ACK_FLAG set.
// [RQ7] Slave read-direction flag follows master direction.
// [RQ8] Address match sets addressed; NOT_ACK_FLAG/STOP clear.
// [RQ9] General call sets flag; status read clears.
// [RQ10] Overrun on load while full; cleared when complete.
// [RQ11] Master NOT_ACK_FLAG sets flag with complete.
// [RQ12] Slave read: master NOT_ACK_FLAG sets flag.
// [RQ13] Slave write: acknowledge every received byte.
// [RQ14] Arbitration lost sets flag with complete.
// [RQ15] Slave stretches clock while buffer not ready.
// [RQ16] End-of-access set when addressed flag clears.
// [RQ17] Enable register: ones enable, zeros ignored.
// [RQ18] Disable register: ones disable, zeros ignored.
// [RQ19] Mask register shows enables, resets to zero.
// [RQ20] Enable bits share status flag positions.
// [RQ21] Receive holding shows last byte, low eight.
// [RQ22] Master complete: low in frame, high after STOP.
// [RQ23] Receive-full set on byte, cleared by read.
// [RQ24] Interrupt high when enabled flag is set.
// [RQ25] Clear-on-read spares flags set during read.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "twu_defs.svh"

module twu_status_irq
(
	// Clock, reset and clock enable.
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               ce,
	// APB slave port.
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Serial engine events, same clock domain.
	input  wire twu_pkg::twu_mode_e mode,
	input  wire logic               shift_load,
	input  wire logic               frame_start,
	input  wire logic               stop_sent,
	input  wire logic               not_ack_flag_det,
	input  wire logic               ack_det,
	input  wire logic               arb_lost,
	input  wire logic               start_det,
	input  wire logic               stop_det,
	input  wire logic               addr_valid,
	input  wire logic [6:0]         addr_byte,
	input  wire logic               addr_read,
	input  wire logic               gcall_det,
	input  wire logic               rx_valid,
	input  wire twu_pkg::twu_byte_t rx_byte,
	input  wire logic [6:0]         own_slave_address,
	// Serial clock pin, sampled here.
	input  wire logic               scl_in,
	output logic                    scl_out,
	output logic                    scl_oe,
	// Engine controls and interrupt.
	output twu_pkg::twu_byte_t      tx_byte,
	output logic                    tx_halt,
	output logic                    ack_drive,
	output logic                    irq
);
	import twu_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Declarations.

	logic       tx_holding_empty_r;   // Transmit holding empty.
	logic       tcomp_r;              // Transfer complete.
	logic       rx_holding_full_r;    // Receive holding full.
	logic       slave_read_dir_r;     // Slave read direction.
	logic       slave_addressed_r;    // Slave addressed.
	logic       general_call_seen_r;  // General call seen.
	logic       overrun_flag_r;       // Overrun.
	logic       not_ack_flag_r;               // Not acknowledge.
	logic       arb_r;                // Arbitration lost.
	logic       clock_stretch_flag_r; // Clock stretched.
	logic       slave_access_end_r;   // End of slave access.
	twu_flags_t imr_r;         // Interrupt mask.
	twu_byte_t  rhr_r;         // Receive holding byte.
	twu_byte_t  thr_r;         // Transmit holding byte.
	logic [31:0] prdata_r;     // Read data register.
	logic       pready_r;      // Ready register.
	logic       pslverr_r;     // Error register.
	logic       irq_r;         // Interrupt register.
	logic       halt_r;        // Slave transmit halt.
	logic       ackd_r;        // Acknowledge drive.
	logic       hold_r;        // Clock stretch drive.
	logic [1:0] scl_sync_r;    // Pin synchroniser.

	////////////////////////////////////////////////////////////////////
	// Bus decode.

	// Master and slave mode selects.
	wire is_m = (mode == TWU_MASTER);
	wire is_s = (mode == TWU_SLAVE);

	// Address hits.
	wire hit_cr  = (paddr == `TWU_OFS_CTRL);
	wire hit_sr  = (paddr == `TWU_OFS_STATUS);
	wire hit_ier = (paddr == `TWU_OFS_IRQ_EN);
	wire hit_idr = (paddr == `TWU_OFS_IRQ_DIS);
	wire hit_imr = (paddr == `TWU_OFS_IRQ_MASK);
	wire hit_rhr = (paddr == `TWU_OFS_RX_HOLD);
	wire hit_thr = (paddr == `TWU_OFS_TX_HOLD);
	wire hit_any = hit_cr | hit_sr | hit_ier | hit_idr |
		hit_imr | hit_rhr | hit_thr;

	// Setup phase and completing access edge.
	wire setup = psel & ~penable;
	wire acc   = ce & psel & penable & pready_r;
	wire wr    = acc & pwrite;
	wire rd    = acc & ~pwrite;

	// Effective register strobes.
	wire wr_ier  = wr & hit_ier;
	wire wr_idr  = wr & hit_idr;
	wire wr_thr  = wr & hit_thr;
	wire wr_master_en = wr & hit_cr & pwdata[`TWU_B_MASTER_EN];
	wire rd_sr   = rd & hit_sr;
	wire rd_rhr  = rd & hit_rhr;

	// Status vector as read.
	wire [31:0] sr_val =
	{
		20'h0_0000,
		slave_access_end_r, clock_stretch_flag_r,
		arb_r, not_ack_flag_r,
		1'b0, overrun_flag_r,
		general_call_seen_r, slave_addressed_r,
		slave_read_dir_r, tx_holding_empty_r,
		rx_holding_full_r, tcomp_r
	} | `TWU_SR_HIGH;

	// Read multiplexer.
	wire [31:0] rd_mux =
		hit_sr  ? sr_val :
		hit_imr ? {20'h0_0000, imr_r} :
		hit_rhr ? {24'h00_0000, rhr_r} :
		`TWU_ZERO32;

	// Clear only the flags that the completed read returned.
	wire [31:0] seen = rd_sr ? prdata_r : `TWU_ZERO32;

	////////////////////////////////////////////////////////////////////
	// Flag events.

	// Master NOT_ACK_FLAG and arbitration loss complete the frame.
	wire m_not_ack_flag = is_m & not_ack_flag_det;
	wire s_not_ack_flag = is_s & not_ack_flag_det & slave_read_dir_r;
	wire m_arb  = is_m & arb_lost;

	// Slave address match and slave end conditions.
	wire s_match = is_s & addr_valid & (addr_byte == own_slave_address);
	wire s_end   = is_s & slave_addressed_r & (not_ack_flag_det | stop_det);

	// Slave byte acknowledged or not.
	wire s_txdone = is_s & slave_read_dir_r & (ack_det | not_ack_flag_det);

	// Stretch while transmit unfilled or receive unread.
	wire stretch = is_s & slave_addressed_r &
		(slave_read_dir_r ? tx_holding_empty_r : rx_holding_full_r);

	// Synchronised serial clock low.
	wire scl_low = ~scl_sync_r[1];

	// Interrupt sources gated by the mask.
	wire [11:0] pend = sr_val[11:0] & imr_r;

	////////////////////////////////////////////////////////////////////
	// APB answer registers; zero-wait access phase.

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= `TWU_ZERO32;
		end
		else if (ce)
		begin
			// Ready in the cycle after setup.
			pready_r  <= setup;
			pslverr_r <= setup & ~hit_any;
			if (setup)
			begin
				prdata_r <= rd_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interrupt mask, set and clear by ones only.

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			imr_r <= `TWU_ZERO12; // RQ19
		end
		else if (ce)
		begin
			// Enables win over disables in the same cycle.
			imr_r <= (imr_r & ~({12{wr_idr}} & pwdata[11:0])) | // RQ18
				({12{wr_ier}} & pwdata[11:0] & `TWU_IRQ_BITS); // RQ17 RQ20
		end
	end

	////////////////////////////////////////////////////////////////////
	// Holding registers.

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rhr_r <= `TWU_ZERO8;
			thr_r <= `TWU_ZERO8;
		end
		else if (ce)
		begin
			// Keep the last received byte.
			if (rx_valid)
			begin
				rhr_r <= rx_byte; // RQ21
			end
			if (wr_thr)
			begin
				thr_r <= pwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Transmit side flags.

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_holding_empty_r <= 1'b0;
			tcomp_r            <= 1'b1;
		end
		else if (ce)
		begin
			// Sets win over the holding register write.
			if (wr_thr)
			begin
				tx_holding_empty_r <= 1'b0; // RQ1 RQ4
			end
			if ((is_m & shift_load) | m_not_ack_flag | wr_master_en)
			begin
				tx_holding_empty_r <= 1'b1; // RQ2 RQ3
			end
			if (s_txdone)
			begin
				tx_holding_empty_r <= 1'b1; // RQ4
			end
			// Complete falls in a frame, rises at its end.
			if ((is_m & frame_start) | (is_s & start_det))
			begin
				tcomp_r <= 1'b0; // RQ22
			end
			if ((is_m & stop_sent) | m_not_ack_flag | m_arb |
				(is_s & stop_det))
			begin
				tcomp_r <= 1'b1; // RQ22 RQ11 RQ14
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Receive and error flags with clear on read.

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_holding_full_r   <= 1'b0;
			overrun_flag_r      <= 1'b0;
			not_ack_flag_r              <= 1'b0;
			arb_r               <= 1'b0;
			general_call_seen_r <= 1'b0;
		end
		else if (ce)
		begin
			// A new byte beats the holding register read.
			rx_holding_full_r <= rx_valid | // RQ23
				(rx_holding_full_r & ~rd_rhr);
			// Overrun cleared only while complete is set.
			overrun_flag_r <= // RQ10 RQ25
				(is_m & rx_valid & rx_holding_full_r) |
				(overrun_flag_r & ~(seen[`TWU_B_OVERRUN] & tcomp_r));
			not_ack_flag_r <= m_not_ack_flag | s_not_ack_flag | // RQ11 RQ12
				(not_ack_flag_r & ~seen[`TWU_B_NOT_ACK_FLAG]); // RQ25
			arb_r <= m_arb | (arb_r & ~seen[`TWU_B_ARB]); // RQ14
			general_call_seen_r <= (is_s & gcall_det) | // RQ9
				(general_call_seen_r & ~seen[`TWU_B_GEN_CALL]); // RQ25
		end
	end

	////////////////////////////////////////////////////////////////////
	// Slave access flags.

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			slave_addressed_r    <= 1'b0;
			slave_read_dir_r     <= 1'b1;
			slave_access_end_r   <= 1'b0;
			clock_stretch_flag_r <= 1'b0;
		end
		else if (ce)
		begin
			// Matching address wins over an end event.
			if (s_match)
			begin
				slave_addressed_r <= 1'b1; // RQ8
				slave_read_dir_r  <= addr_read; // RQ7
			end
			else if (s_end)
			begin
				slave_addressed_r <= 1'b0; // RQ8
			end
			slave_access_end_r <= (s_end & ~s_match) | // RQ16
				(slave_access_end_r & ~seen[`TWU_B_ACC_END]); // RQ25
			// Stretch shows once the pin is held low.
			clock_stretch_flag_r <= stretch & scl_low; // RQ15
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin synchroniser and registered outputs.

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_sync_r <= 2'b11;
			hold_r     <= 1'b0;
			halt_r     <= 1'b0;
			ackd_r     <= 1'b0;
			irq_r      <= 1'b0;
		end
		else if (ce)
		begin
			scl_sync_r <= {scl_sync_r[0], scl_in};
			hold_r     <= stretch; // RQ15
			halt_r     <= is_s & tx_holding_empty_r & not_ack_flag_r; // RQ5
			ackd_r     <= is_s & slave_addressed_r & ~slave_read_dir_r; // RQ13
			irq_r      <= |pend; // RQ24
		end
	end

	// Outputs straight from flip-flops; scl_out is a constant zero.
	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign tx_byte = thr_r;
	assign tx_halt = halt_r;
	assign ack_drive = ackd_r;
	assign irq     = irq_r;
	assign scl_oe  = hold_r;
	assign scl_out = 1'b0 & hold_r;

	////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// A completed write of the transmit holding register.
	sequence s_thr_write;
		ce && wr_thr && is_m && !shift_load && !m_not_ack_flag && !wr_master_en;
	endsequence

	property p_thr_clear;
		s_thr_write |=> !tx_holding_empty_r;
	endproperty
	a_thr_clear: assert property (p_thr_clear) // RQ1
		else $error("transmit empty not cleared by write");

	property p_load_set;
		ce && is_m && shift_load |=> tx_holding_empty_r;
	endproperty
	a_load_set: assert property (p_load_set) // RQ2
		else $error("transmit empty not set on load");

	property p_master_enable_cmd_set;
		ce && wr_master_en |=> tx_holding_empty_r;
	endproperty
	a_master_enable_cmd_set: assert property (p_master_enable_cmd_set) // RQ3
		else $error("transmit empty not set on enable");

	property p_not_ack_flag_cmp;
		ce && m_not_ack_flag |=> not_ack_flag_r && tcomp_r && tx_holding_empty_r;
	endproperty
	a_not_ack_flag_cmp: assert property (p_not_ack_flag_cmp) // RQ11
		else $error("not_ack_flag without complete");

	property p_match;
		ce && s_match |=> slave_addressed_r &&
			(slave_read_dir_r == $past(addr_read));
	endproperty
	a_match: assert property (p_match) // RQ8
		else $error("address match not flagged");

	property p_eos;
		ce && slave_addressed_r && s_end && !s_match |=>
			!slave_addressed_r && slave_access_end_r;
	endproperty
	a_eos: assert property (p_eos) // RQ16
		else $error("end of access not flagged");

	property p_general_call_seen_keep;
		ce && is_s && gcall_det && rd_sr |=> general_call_seen_r;
	endproperty
	a_general_call_seen_keep: assert property (p_general_call_seen_keep) // RQ25
		else $error("general call lost on read");

	property p_rxfull;
		ce && rx_valid |=> rx_holding_full_r ##0 (rhr_r == $past(rx_byte));
	endproperty
	a_rxfull: assert property (p_rxfull) // RQ23
		else $error("receive full not set");

	property p_irq;
		ce |=> irq_r == |$past(pend);
	endproperty
	a_irq: assert property (p_irq) // RQ24
		else $error("interrupt does not follow mask");

	property p_arb;
		ce && m_arb |=> arb_r && tcomp_r;
	endproperty
	a_arb: assert property (p_arb) // RQ14
		else $error("arbitration loss not flagged");

endmodule

// ### test/twu_far_end.sv
`timescale 1ns/1ps

module twu_far_end
(
	// Clock and reset.
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Command from the bench: 1 address, 2 byte, 3 stop.
	input  wire logic [1:0] cmd,
	input  wire logic [7:0] val,
	// Slave-side engine events seen from the far device.
	output logic            start_det,
	output logic            stop_det,
	output logic            addr_valid,
	output logic [6:0]      addr_byte,
	output logic            addr_read,
	output logic            rx_valid,
	output logic [7:0]      rx_byte,
	// Serial clock as the far device drives it.
	output logic            scl_in
);
	logic       in_frame_r; // High from START to STOP.
	logic       addr_pend_r; // Address follows START by one cycle.
	logic [1:0] div_r;       // Four cycles give each 160 ns half period.

	////////////////////////////////////////////////////////////////////////
	// Events are one-cycle pulses; data buses invert once no longer valid,
	// so a design that samples late sees a wrong value.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			in_frame_r  <= 1'b0;
			addr_pend_r <= 1'b0;
			div_r       <= 2'd0;
			start_det   <= 1'b0;
			stop_det    <= 1'b0;
			addr_valid  <= 1'b0;
			addr_byte   <= 7'h00;
			addr_read   <= 1'b0;
			rx_valid    <= 1'b0;
			rx_byte     <= 8'h00;
			scl_in      <= 1'b1;
		end
		else
		begin
			start_det   <= (cmd == 2'd1);
			stop_det    <= (cmd == 2'd3);
			rx_valid    <= (cmd == 2'd2);
			addr_valid  <= addr_pend_r;
			addr_pend_r <= (cmd == 2'd1);
			div_r       <= div_r + 2'd1;
			if (cmd == 2'd1)
			begin
				in_frame_r <= 1'b1;
				addr_byte  <= val[6:0];
				addr_read  <= val[7];
			end
			else if (addr_valid)
				addr_byte <= ~addr_byte;
			if (cmd == 2'd3)
				in_frame_r <= 1'b0;
			if (cmd == 2'd2)
				rx_byte <= val;
			else if (rx_valid)
				rx_byte <= ~rx_byte;
			// The link clock stands high on its pull-up outside frames.
			if (!in_frame_r)
				scl_in <= 1'b1;
			else if (div_r == 2'd3)
				scl_in <= ~scl_in;
		end
	end
endmodule

// ### test/twu_status_irq_tb_top.sv
`timescale 1ns/1ps
`include "twu_defs.svh"

module twu_status_irq_tb_top;
	import twu_pkg::*;

	// Bench clock, reset and APB master signals.
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	// Engine inputs from the bench and from the far device.
	twu_mode_e   mode = TWU_IDLE;
	logic [6:0]  evt = 7'h00;
	logic [6:0]  own = 7'h2A;
	logic [1:0]  cmd = 2'd0;
	logic [7:0]  val = 8'h00;
	logic        start_det, stop_det, addr_valid, addr_read, rx_valid;
	logic        scl_in, scl_oe, ack_drive, irq;
	logic        scl_out, tx_halt;
	logic        ce = 1'b1;
	// The serial clock line is wired-AND: a stretch holds it low.
	wire         scl_pin = scl_in & ~scl_oe;
	logic [6:0]  addr_byte;
	logic [7:0]  rx_byte;
	twu_byte_t   tx_byte;
	int          miscompares = 0;
	int          samples_checked = 0;

	always #20 pclk = ~pclk;

	twu_far_end i_twu_far_end (.pclk(pclk), .presetn(presetn), .cmd(cmd),
		.val(val), .start_det(start_det), .stop_det(stop_det),
		.addr_valid(addr_valid), .addr_byte(addr_byte),
		.addr_read(addr_read), .rx_valid(rx_valid), .rx_byte(rx_byte),
		.scl_in(scl_in));

	twu_status_irq i_twu_status_irq (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mode(mode), .shift_load(evt[0]),
		.frame_start(evt[1]), .stop_sent(evt[2]), .not_ack_flag_det(evt[3]),
		.ack_det(evt[4]), .arb_lost(evt[5]), .start_det(start_det),
		.stop_det(stop_det), .addr_valid(addr_valid),
		.addr_byte(addr_byte), .addr_read(addr_read),
		.gcall_det(evt[6]), .rx_valid(rx_valid), .rx_byte(rx_byte),
		.own_slave_address(own), .scl_in(scl_pin), .scl_out(scl_out),
		.scl_oe(scl_oe), .tx_byte(tx_byte), .tx_halt(tx_halt),
		.ack_drive(ack_drive), .irq(irq));

	////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then ends the run.
	task automatic close_out;
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] x);
		samples_checked++;
		if (s !== x)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, x, s);
		end
	endtask

	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer.
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Write, read and masked-status helpers on top of the transfer.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		chk("register", q, x);
	endtask

	task automatic sr(input logic [31:0] m, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, `TWU_OFS_STATUS, 32'h0000_0000, q, e);
		chk("status", q & m, x);
	endtask

	// Engine event pulse of one cycle, then time to settle.
	task automatic pulse(input logic [6:0] m);
		@(posedge pclk);
		evt <= m;
		@(posedge pclk);
		evt <= 7'h00;
		repeat (2) @(posedge pclk);
	endtask

	// One command to the far device, then time to settle.
	task automatic far(input logic [1:0] c, input logic [7:0] v);
		@(posedge pclk);
		cmd <= c;
		val <= v;
		@(posedge pclk);
		cmd <= 2'd0;
		repeat (4) @(posedge pclk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Watchdog: the tests need well under a tenth of this span.
	initial
	begin
		#2_000_000;
		miscompares++;
		close_out();
	end

	// Main sequence.
	initial
	begin
		logic [31:0] q;
		logic        e;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		sr(32'hFFFF_FFFF, 32'h0000_F009);
		rd(`TWU_OFS_IRQ_MASK, 32'h0000_0000);
		rd(`TWU_OFS_RX_HOLD, 32'h0000_0000);
		wr(`TWU_OFS_IRQ_EN, 32'hFFFF_FFFF);
		rd(`TWU_OFS_IRQ_MASK, 32'h0000_0F77);
		wr(`TWU_OFS_IRQ_EN, 32'h0000_0000);
		rd(`TWU_OFS_IRQ_MASK, 32'h0000_0F77);
		wr(`TWU_OFS_IRQ_DIS, 32'h0000_0104);
		rd(`TWU_OFS_IRQ_MASK, 32'h0000_0E73);
		wr(`TWU_OFS_IRQ_DIS, 32'h0000_0000);
		rd(`TWU_OFS_IRQ_MASK, 32'h0000_0E73);
		wr(`TWU_OFS_IRQ_DIS, 32'hFFFF_FFFF);
		rd(`TWU_OFS_IRQ_MASK, 32'h0000_0000);
		apb(1'b0, 8'h3C, 32'h0000_0000, q, e);
		chk("unmapped error", {31'h0, e}, 32'h0000_0001);
		// Master: enable command, holding write, shifter load, frame.
		mode <= TWU_MASTER;
		wr(`TWU_OFS_CTRL, 32'h0000_0004);
		sr(32'h0000_0004, 32'h0000_0004);
		wr(`TWU_OFS_TX_HOLD, 32'h0000_005A);
		sr(32'h0000_0004, 32'h0000_0000);
		pulse(7'h01);
		sr(32'h0000_0004, 32'h0000_0004);
		pulse(7'h02);
		sr(32'h0000_0001, 32'h0000_0000);
		pulse(7'h04);
		sr(32'h0000_0001, 32'h0000_0001);
		// Two bytes without a holding read cause an overrun.
		far(2'd2, 8'h3C);
		sr(32'h0000_0042, 32'h0000_0002);
		far(2'd2, 8'hC3);
		sr(32'h0000_0042, 32'h0000_0042);
		sr(32'h0000_0040, 32'h0000_0000);
		rd(`TWU_OFS_RX_HOLD, 32'h0000_00C3);
		sr(32'h0000_0002, 32'h0000_0000);
		// Not-acknowledge with its interrupt, then arbitration lost.
		wr(`TWU_OFS_IRQ_EN, 32'h0000_0100);
		pulse(7'h02);
		pulse(7'h08);
		chk("irq", {31'h0, irq}, 32'h0000_0001);
		sr(32'h0000_0105, 32'h0000_0105);
		sr(32'h0000_0100, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		chk("irq", {31'h0, irq}, 32'h0000_0000);
		wr(`TWU_OFS_IRQ_DIS, 32'h0000_0100);
		pulse(7'h02);
		pulse(7'h20);
		sr(32'h0000_0201, 32'h0000_0201);
		sr(32'h0000_0200, 32'h0000_0000);
		// Slave written by the far master, with a stretch on a full byte.
		mode <= TWU_SLAVE;
		far(2'd1, 8'h2A);
		sr(32'h0000_0019, 32'h0000_0010);
		chk("ack drive", {31'h0, ack_drive}, 32'h0000_0001);
		far(2'd2, 8'h77);
		chk("stretch", {31'h0, scl_oe}, 32'h0000_0001);
		chk("scl out", {31'h0, scl_out}, 32'h0000_0000);
		sr(32'h0000_0400, 32'h0000_0400);
		rd(`TWU_OFS_RX_HOLD, 32'h0000_0077);
		repeat (3) @(posedge pclk);
		chk("stretch", {31'h0, scl_oe}, 32'h0000_0000);
		sr(32'h0000_0400, 32'h0000_0000);
		far(2'd3, 8'h00);
		sr(32'h0000_0811, 32'h0000_0801);
		sr(32'h0000_0800, 32'h0000_0000);
		// Read direction, a foreign address and a general call.
		far(2'd1, 8'hAA);
		sr(32'h0000_0018, 32'h0000_0018);
		// Slave transmit: holding write, acknowledged, then not.
		wr(`TWU_OFS_TX_HOLD, 32'h0000_00A5);
		@(posedge pclk);
		chk("tx byte", {24'h0, tx_byte}, 32'h0000_00A5);
		sr(32'h0000_0004, 32'h0000_0000);
		pulse(7'h10);
		sr(32'h0000_0004, 32'h0000_0004);
		pulse(7'h08);
		// No holding write follows while the not-acknowledge stands.
		chk("tx halt", {31'h0, tx_halt}, 32'h0000_0001);
		sr(32'h0000_0114, 32'h0000_0104);
		far(2'd3, 8'h00);
		far(2'd1, 8'h15);
		sr(32'h0000_0010, 32'h0000_0000);
		far(2'd3, 8'h00);
		// Clock enable low freezes the flags against an event.
		ce <= 1'b0;
		pulse(7'h40);
		ce <= 1'b1;
		sr(32'h0000_0020, 32'h0000_0000);
		pulse(7'h40);
		sr(32'h0000_0020, 32'h0000_0020);
		sr(32'h0000_0020, 32'h0000_0000);
		close_out();
	end
endmodule
